// *** rtl/rtcu_map.vh ***
// Notes on behaviour
// - timer coil on when accumulated >= preset
// - powered timer steps every tenth second
// - timer clears when rung power drops
// - counter coil on when accumulated >= preset
// - counter steps on off-to-on control edges
// - counter reset line clears accumulated value
`ifndef RTCU_MAP_VH
`define RTCU_MAP_VH

// accumulated and preset value width
`define RTCU_ACC_W 16
// ordinary timers and counters, fixed-preset references
`define RTCU_NUM_TMR 4
`define RTCU_NUM_CTR 4
// dial-preset references per kind
`define RTCU_NUM_DIAL 4
// dial digits per setpoint, four bits each
`define RTCU_DIAL_DIGITS 4
// time base step in ns and clock period in ns
`define RTCU_TENTH_SEC_NS 100000000
`define RTCU_CLK_PERIOD_NS 10
// clock cycles per tenth of a second
`define RTCU_TICK_CYCLES (`RTCU_TENTH_SEC_NS / `RTCU_CLK_PERIOD_NS)
// reset value of accumulators and presets
`define RTCU_ACC_RST 16'h0000
// element kinds
`define RTCU_KIND_TMR 1'b0
`define RTCU_KIND_CTR 1'b1
// largest legal decimal digit
`define RTCU_DIGIT_MAX 4'h9

`endif

// *** rtl/rtcu_elem.v ***
`timescale 1ns/10ps
`include "rtcu_map.vh"

// one timer or counter element with its output coil
module rtcu_elem #(
  parameter ACC_W = `RTCU_ACC_W,
  parameter KIND = `RTCU_KIND_TMR
) (
  // clock and reset
  input wire clk_i,
  input wire rstn_i,
  // time base step, one cycle
  input wire tick_i,
  // rung power to the element, control line for counters
  input wire power_i,
  // counter reset line, unused by timers
  input wire clear_i,
  // preset to compare against
  input wire [ACC_W-1:0] preset_i,
  // element state
  output wire [ACC_W-1:0] acc_o,
  output wire coil_o
);

  reg [ACC_W-1:0] acc_r; // accumulated value
  reg [ACC_W-1:0] acc_nxt;
  reg prev_r; // control line last scan
  reg coil_r; // output coil
  wire at_max; // holds the value at full scale
  wire rise; // off-to-on transition

  assign at_max = &acc_r;
  assign rise = power_i & ~prev_r;

  // next accumulated value
  always @* begin
    acc_nxt = acc_r;
    if (KIND == `RTCU_KIND_TMR) begin
      if (!power_i) begin
        acc_nxt = `RTCU_ACC_RST;
      end else if (tick_i && !at_max) begin
        acc_nxt = acc_r + {{(ACC_W-1){1'b0}}, 1'b1};
      end
    end else begin
      if (clear_i) begin
        acc_nxt = `RTCU_ACC_RST;
      end else if (rise && !at_max) begin
        acc_nxt = acc_r + {{(ACC_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // state registers, coil follows the new value
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_r <= `RTCU_ACC_RST;
      prev_r <= 1'b0;
      coil_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      prev_r <= power_i;
      coil_r <= (acc_nxt >= preset_i);
    end
  end

  assign acc_o = acc_r;
  assign coil_o = coil_r;

endmodule // rtcu_elem

// *** rtl/rtcu_top.v ***
`timescale 1ns/10ps
`include "rtcu_map.vh"

// timer and counter unit driven by rung power flow
module rtcu_top #(
  parameter ACC_W = `RTCU_ACC_W,
  parameter NUM_TMR = `RTCU_NUM_TMR,
  parameter NUM_CTR = `RTCU_NUM_CTR,
  parameter NUM_DIAL = `RTCU_NUM_DIAL,
  parameter TICK_CYCLES = `RTCU_TICK_CYCLES
) (
  // clock and reset
  input wire clk_i,
  input wire rstn_i,
  // ordinary timers: rung power and preset
  input wire [NUM_TMR-1:0] tmr_power_i,
  input wire [NUM_TMR*ACC_W-1:0] tmr_preset_i,
  // dial timers: rung power
  input wire [NUM_DIAL-1:0] dtmr_power_i,
  // ordinary counters: control, reset line and preset
  input wire [NUM_CTR-1:0] ctr_power_i,
  input wire [NUM_CTR-1:0] ctr_clear_i,
  input wire [NUM_CTR*ACC_W-1:0] ctr_preset_i,
  // dial counters: control and reset line
  input wire [NUM_DIAL-1:0] dctr_power_i,
  input wire [NUM_DIAL-1:0] dctr_clear_i,
  // external setpoint dials, decimal digits, timers then counters
  input wire [2*NUM_DIAL*`RTCU_DIAL_DIGITS*4-1:0] dial_digits_i,
  // timer state
  output wire [(NUM_TMR+NUM_DIAL)*ACC_W-1:0] tmr_acc_o,
  output wire [NUM_TMR+NUM_DIAL-1:0] tmr_coil_o,
  // counter state
  output wire [(NUM_CTR+NUM_DIAL)*ACC_W-1:0] ctr_acc_o,
  output wire [NUM_CTR+NUM_DIAL-1:0] ctr_coil_o,
  // a dial shows a digit above nine
  output wire [2*NUM_DIAL-1:0] dial_err_o,
  // time base step, for observation
  output wire tick_o
);

  localparam DIG = `RTCU_DIAL_DIGITS; // digits per dial
  localparam DW = DIG * 4; // bits per dial
  localparam NDIAL = 2 * NUM_DIAL; // dials, timers first
  localparam NT = NUM_TMR + NUM_DIAL; // all timers
  localparam NC = NUM_CTR + NUM_DIAL; // all counters
  // prescaler counter, 32 bits, wide enough for a tenth of a second at clocks up to about 42.9 GHz
  localparam TW = 32; // prescaler width

  // prescaler state, one-hot
  localparam ST_RUN = 2'b01; // counting toward a step
  localparam ST_STEP = 2'b10; // step cycle

  reg [1:0] st_r; // prescaler state
  reg [1:0] st_nxt;
  reg [TW-1:0] div_r; // cycles since last step
  reg [TW-1:0] div_nxt;
  reg tick_r; // one-cycle tenth-second step
  wire [TW-1:0] div_last; // last count before a step

  // the step cycle itself closes each period, so the count stops two short;
  // out of reset the first step comes one cycle early, within one period
  assign div_last = TICK_CYCLES - 2;

  // prescaler next state
  always @* begin
    st_nxt = st_r;
    div_nxt = div_r;
    case (st_r)
      ST_RUN: begin
        // reach the step after TICK_CYCLES edges in total
        if (div_r >= div_last) begin
          st_nxt = ST_STEP;
          div_nxt = {TW{1'b0}};
        end else begin
          div_nxt = div_r + {{(TW-1){1'b0}}, 1'b1};
        end
      end
      ST_STEP: begin
        // single step cycle, then back to counting
        st_nxt = ST_RUN;
      end
      default: begin
        // unknown code, restart the period
        st_nxt = ST_RUN;
        div_nxt = {TW{1'b0}};
      end
    endcase
  end

  // prescaler registers, free running time base
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= ST_RUN;
      div_r <= {TW{1'b0}};
      tick_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      tick_r <= (st_nxt == ST_STEP);
    end
  end

  assign tick_o = tick_r;

  // dial presets, converted from decimal digits
  // a dial turned by hand passes through odd readings, so a reading
  // with any digit above nine is refused and the last good preset stays
  wire [NDIAL*ACC_W-1:0] dial_preset; // held binary preset per dial

  genvar d;
  generate
    for (d = 0; d < NDIAL; d = d + 1) begin : g_dial
      wire [DW-1:0] digits; // this dial, most significant digit on top
      wire [3:0] d3; // thousands
      wire [3:0] d2; // hundreds
      wire [3:0] d1; // tens
      wire [3:0] d0; // units
      wire bad; // any digit out of range
      wire [ACC_W-1:0] bin; // binary value of the digits
      reg [ACC_W-1:0] pre_r; // last good preset of this dial
      reg err_r; // this dial shows a bad reading

      assign digits = dial_digits_i[d*DW +: DW];
      assign d3 = digits[15:12];
      assign d2 = digits[11:8];
      assign d1 = digits[7:4];
      assign d0 = digits[3:0];
      assign bad = (d3 > `RTCU_DIGIT_MAX) | (d2 > `RTCU_DIGIT_MAX) |
                   (d1 > `RTCU_DIGIT_MAX) | (d0 > `RTCU_DIGIT_MAX);
      // weights 1000, 100, 10, 1, all within sixteen bits
      assign bin = d3 * 16'h03e8 + d2 * 16'h0064 + d1 * 16'h000a + {12'h000, d0};

      // dial sampling, a bad reading keeps the last good preset
      always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          pre_r <= `RTCU_ACC_RST;
          err_r <= 1'b0;
        end else begin
          // error flag follows every reading, good or bad
          err_r <= bad;
          if (!bad) begin
            // good reading, take it as the new preset
            pre_r <= bin;
          end
        end
      end

      // one slice of the shared preset and error buses per dial
      assign dial_preset[d*ACC_W +: ACC_W] = pre_r;
      assign dial_err_o[d] = err_r;
    end
  endgenerate

  // timers: fixed presets first, dial presets on the last references
  genvar t;
  generate
    for (t = 0; t < NT; t = t + 1) begin : g_tmr
      wire pw; // rung power to this timer
      wire [ACC_W-1:0] pre; // preset source

      // the last references of this kind take their preset from a dial
      if (t < NUM_TMR) begin : g_fixed
        assign pw = tmr_power_i[t];
        assign pre = tmr_preset_i[t*ACC_W +: ACC_W];
      end else begin : g_dialed
        assign pw = dtmr_power_i[t-NUM_TMR];
        assign pre = dial_preset[(t-NUM_TMR)*ACC_W +: ACC_W];
      end

      // timers have no reset line; loss of power clears them
      rtcu_elem #(
        .ACC_W(ACC_W),
        .KIND(`RTCU_KIND_TMR)
      ) u_tmr (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .tick_i(tick_r),
        .power_i(pw),
        .clear_i(1'b0),
        .preset_i(pre),
        .acc_o(tmr_acc_o[t*ACC_W +: ACC_W]),
        .coil_o(tmr_coil_o[t])
      );
    end
  endgenerate

  // counters: fixed presets first, dial presets on the last references
  genvar c;
  generate
    for (c = 0; c < NC; c = c + 1) begin : g_ctr
      wire pw; // control line
      wire cl; // reset line
      wire [ACC_W-1:0] pre; // preset source

      // the last references of this kind take their preset from a dial
      if (c < NUM_CTR) begin : g_fixed
        assign pw = ctr_power_i[c];
        assign cl = ctr_clear_i[c];
        assign pre = ctr_preset_i[c*ACC_W +: ACC_W];
      end else begin : g_dialed
        assign pw = dctr_power_i[c-NUM_CTR];
        assign cl = dctr_clear_i[c-NUM_CTR];
        // counter dials follow the timer dials
        assign pre = dial_preset[(c-NUM_CTR+NUM_DIAL)*ACC_W +: ACC_W];
      end

      // counters take no time base, only control edges
      rtcu_elem #(
        .ACC_W(ACC_W),
        .KIND(`RTCU_KIND_CTR)
      ) u_ctr (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .tick_i(1'b0),
        .power_i(pw),
        .clear_i(cl),
        .preset_i(pre),
        .acc_o(ctr_acc_o[c*ACC_W +: ACC_W]),
        .coil_o(ctr_coil_o[c])
      );
    end
  endgenerate

endmodule // rtcu_top

// *** bench/rtcu_chk.sv ***
`timescale 1ns/10ps
// element 0 of each kind and the time base (bench runs 4-cycle ticks)
module rtcu_chk #(parameter ACC_W = 16, NUM_TMR = 4, NUM_CTR = 4, NUM_DIAL = 4) (
  // clock and reset
  input wire clk_i,
  input wire rstn_i,
  // rung side
  input wire [NUM_TMR-1:0] tmr_power_i,
  input wire [NUM_TMR*ACC_W-1:0] tmr_preset_i,
  input wire [NUM_CTR-1:0] ctr_power_i,
  input wire [NUM_CTR-1:0] ctr_clear_i,
  input wire [NUM_CTR*ACC_W-1:0] ctr_preset_i,
  // element state
  input wire [(NUM_TMR+NUM_DIAL)*ACC_W-1:0] tmr_acc_o,
  input wire [NUM_TMR+NUM_DIAL-1:0] tmr_coil_o,
  input wire [(NUM_CTR+NUM_DIAL)*ACC_W-1:0] ctr_acc_o,
  input wire [NUM_CTR+NUM_DIAL-1:0] ctr_coil_o,
  input wire tick_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire [15:0] ta = tmr_acc_o[15:0]; // timer 0 value
  wire [15:0] ca = ctr_acc_o[15:0]; // counter 0 value
  property p_tclr; !tmr_power_i[0] |=> ta == 0; endproperty
  a_tclr: assert property (p_tclr) else $error("timer kept value");
  property p_tstep; tmr_power_i[0] && tick_o && ta != 16'hffff |=> ta == $past(ta) + 16'h0001; endproperty
  a_tstep: assert property (p_tstep) else $error("timer missed step");
  property p_tick; tick_o |=> (!tick_o)[*3] ##1 tick_o; endproperty
  a_tick: assert property (p_tick) else $error("tick period wrong");
  property p_tcoil; $past(rstn_i) |-> tmr_coil_o[0] == (ta >= $past(tmr_preset_i[15:0])); endproperty
  a_tcoil: assert property (p_tcoil) else $error("timer coil wrong");
  property p_cup; ctr_power_i[0] && !$past(ctr_power_i[0]) && !ctr_clear_i[0] && ca != 16'hffff
    |=> ca == $past(ca) + 16'h0001; endproperty
  a_cup: assert property (p_cup) else $error("counter missed edge");
  property p_cclr; ctr_clear_i[0] |=> ca == 0; endproperty
  a_cclr: assert property (p_cclr) else $error("counter not cleared");
  property p_cwin; ctr_clear_i[0] && $rose(ctr_power_i[0])
    |=> ca == 0 && ctr_coil_o[0] == ($past(ctr_preset_i[15:0]) == 16'h0000); endproperty
  a_cwin: assert property (p_cwin) else $error("count beat clear");
  property p_ccoil; $past(rstn_i) |-> ctr_coil_o[0] == (ca >= $past(ctr_preset_i[15:0])); endproperty
  a_ccoil: assert property (p_ccoil) else $error("counter coil wrong");
  c_tcoil: cover property (tmr_coil_o[0]);
  c_ccoil: cover property (ctr_coil_o[0]);
  c_cwin: cover property (ctr_clear_i[0] && ctr_power_i[0]);
endmodule // rtcu_chk
bind rtcu_top rtcu_chk #(.ACC_W(ACC_W), .NUM_TMR(NUM_TMR), .NUM_CTR(NUM_CTR), .NUM_DIAL(NUM_DIAL)) chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .tmr_power_i(tmr_power_i), .tmr_preset_i(tmr_preset_i),
  .ctr_power_i(ctr_power_i), .ctr_clear_i(ctr_clear_i), .ctr_preset_i(ctr_preset_i), .tmr_acc_o(tmr_acc_o),
  .tmr_coil_o(tmr_coil_o), .ctr_acc_o(ctr_acc_o), .ctr_coil_o(ctr_coil_o), .tick_o(tick_o));

// *** bench/rtcu_dial_model.sv ***
`timescale 1ns/10ps
// setpoint dial bank: one setpoint on the four timer dials, another on the four counter dials
module rtcu_dial_model (
  // setpoints, 0 to 9999, for timer dials and counter dials
  input wire [15:0] tset_i,
  input wire [15:0] cset_i,
  // digits, thousands in the top nibble, timer dials in the low half
  output wire [127:0] dial_o
);
  // decimal split of each setpoint
  wire [15:0] tbcd = {4'(tset_i / 1000), 4'(tset_i / 100 % 10), 4'(tset_i / 10 % 10), 4'(tset_i % 10)};
  wire [15:0] cbcd = {4'(cset_i / 1000), 4'(cset_i / 100 % 10), 4'(cset_i / 10 % 10), 4'(cset_i % 10)};
  assign dial_o = {{4{cbcd}}, {4{tbcd}}};
endmodule // rtcu_dial_model

// *** bench/tb.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module tb;
  reg clk_i = 0;
  reg rstn_i = 0;
  reg [3:0] tp = 0, dtp = 0, cp = 0, cc = 0, dcp = 0, dcc = 0; // rung lines
  reg [63:0] tpre = {4{16'h0003}}, cpre = {4{16'h0002}}; // fixed presets
  reg [15:0] tset = 16'h000c, cset = 16'h0003; // dial setpoints
  reg bad = 0; // forces a digit above nine on dial 0
  wire [127:0] dial, tacc, cacc;
  wire [127:0] dial_in = {dial[127:16], dial[15:12] | {4{bad}}, dial[11:0]};
  wire [7:0] tcoil, ccoil, derr;
  wire [15:0] coils = {ccoil, tcoil};
  int num_errors = 0, n_tests = 0;
  rtcu_dial_model dm (.tset_i(tset), .cset_i(cset), .dial_o(dial));
  rtcu_top #(.TICK_CYCLES(4)) uut (.clk_i(clk_i), .rstn_i(rstn_i), .tmr_power_i(tp), .tmr_preset_i(tpre),
    .dtmr_power_i(dtp), .ctr_power_i(cp), .ctr_clear_i(cc), .ctr_preset_i(cpre), .dctr_power_i(dcp),
    .dctr_clear_i(dcc), .dial_digits_i(dial_in), .tmr_acc_o(tacc), .tmr_coil_o(tcoil), .ctr_acc_o(cacc),
    .ctr_coil_o(ccoil), .dial_err_o(derr), .tick_o());
  initial forever #5 clk_i = ~clk_i;
  task results;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // bounded wait for a coil
  task wt(input int k);
    int i;
    for (i = 0; i < 100 && coils[k] !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (i == 100) begin
      num_errors++;
      $display("BAD %0t coil wait", $time);
      results;
    end
  endtask
  // one off-on-off control pulse
  task pulse(input bit d);
    @(posedge clk_i);
    if (d) dcp[0] <= 1;
    else cp[0] <= 1;
    @(posedge clk_i);
    dcp[0] <= 0;
    cp[0] <= 0;
  endtask
  task t_timer;
    @(posedge clk_i);
    tp[0] <= 1;
    wt(0);
    `CHK(tacc[15:0], 16'h0003)
    @(posedge clk_i);
    tp[0] <= 0;
    @(posedge clk_i);
    #1;
    `CHK(tacc[15:0], 16'h0000)
    `CHK(tcoil[0], 1'b0)
    $display("timer done");
  endtask
  task t_counter;
    pulse(0);
    pulse(0);
    @(posedge clk_i);
    #1;
    `CHK(cacc[15:0], 16'h0002)
    `CHK(ccoil[0], 1'b1)
    @(posedge clk_i);
    cp[0] <= 1;
    repeat (4) @(posedge clk_i);
    #1;
    `CHK(cacc[15:0], 16'h0003)
    @(posedge clk_i);
    cp[0] <= 0;
    @(posedge clk_i);
    cp[0] <= 1;
    cc[0] <= 1;
    @(posedge clk_i);
    cp[0] <= 0;
    cc[0] <= 0;
    @(posedge clk_i);
    #1;
    `CHK(cacc[15:0], 16'h0000)
    `CHK(ccoil[0], 1'b0)
    $display("counter done");
  endtask
  task t_dial;
    @(posedge clk_i);
    dtp[0] <= 1;
    wt(4);
    `CHK(tacc[79:64], 16'h000c)
    @(posedge clk_i);
    bad <= 1;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(derr, 8'h01)
    `CHK(tcoil[4], 1'b1)
    @(posedge clk_i);
    bad <= 0;
    pulse(1);
    pulse(1);
    pulse(1);
    @(posedge clk_i);
    #1;
    `CHK(cacc[79:64], 16'h0003)
    `CHK(ccoil[4], 1'b1)
    `CHK(derr, 8'h00)
    @(posedge clk_i);
    dcc[0] <= 1;
    @(posedge clk_i);
    dcc[0] <= 0;
    @(posedge clk_i);
    #1;
    `CHK(cacc[79:64], 16'h0000)
    `CHK(ccoil[4], 1'b0)
    $display("dial done");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rstn_i <= 1;
    t_timer;
    t_counter;
    t_dial;
    results;
  end
endmodule // tb
